// *** design/luma_sharpness_level_adjust.sv ***
// Luma peaking, coring, contrast, brightness and width reduction for one window.
// Assumes an APB master for the registers and a stream source of pixel samples.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module luma_sharpness_level_adjust (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire logic s_valid,
	output logic s_ready,
	input wire luma_adjust_pkg::pix_in_s s_pix,
	output logic m_valid,
	input wire logic m_ready,
	output luma_adjust_pkg::pix_out_s m_pix
);
	import luma_adjust_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register file.

	logic [11:0] sharp_reg; // Coring, peaking, bypass, swap, centre.
	logic [11:0] offset_reg; // Brightness offset and floor enable.
	logic [11:0] gain_reg; // Gain, reduction, clamp and skips.
	logic [3:0] fifo_level; // Output buffer fill.
	logic [1:0] err_reg; // Reduction error carried between samples.
	logic s1_v, s2_v, s3_v, s4_v, s5_v; // Stage valid flags.

	// Maps a byte address to a register slot; 4 means unmapped.
	function automatic logic [2:0] slot_of(input logic [11:0] a);
		case (a)
			ADDR_SHARP: slot_of = 3'h0;
			ADDR_OFFSET: slot_of = 3'h1;
			ADDR_GAIN: slot_of = 3'h2;
			ADDR_STATUS: slot_of = 3'h3;
			default: slot_of = 3'h4;
		endcase
	endfunction

	// Answer one cycle after setup, so the access phase always ends at once.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= (slot_of(paddr) == 3'h4);
			case (slot_of(paddr))
				3'h0: prdata <= {20'h0, sharp_reg};
				3'h1: prdata <= {20'h0, offset_reg};
				3'h2: prdata <= {20'h0, gain_reg};
				3'h3: prdata <= {24'h0, err_reg, s1_v | s2_v | s3_v | s4_v | s5_v, 1'b0, fifo_level};
				default: prdata <= '0;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Writes land at the access edge; reserved bits are masked to zero.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			sharp_reg <= SHARP_RST;
			offset_reg <= OFFSET_RST;
			gain_reg <= GAIN_RST;
		end else if (psel && penable && pready && pwrite) begin
			case (slot_of(paddr))
				3'h0: sharp_reg <= pwdata[11:0] & SHARP_MASK;
				3'h1: offset_reg <= pwdata[11:0] & OFFSET_MASK;
				3'h2: gain_reg <= pwdata[11:0] & GAIN_MASK;
				default: sharp_reg <= sharp_reg;
			endcase
		end
	end

	// Field views of the control words.
	logic [1:0] core_sel;
	logic [2:0] peak_gain;
	logic [1:0] freq_sel;
	logic [7:0] luma_offset;
	logic luma_floor_enable_w1;
	logic [5:0] luma_gain_factor_w1;
	reduce_e width_reduce_mode_w1;
	logic clamp_level_select_w1;
	logic offset_adder_skip_w1;
	logic gain_multiplier_skip_w1;
	assign core_sel = sharp_reg[CORE_LSB +: 2];
	assign peak_gain = sharp_reg[PEAK_LSB +: 3];
	assign freq_sel = sharp_reg[FREQ_LSB +: 2];
	assign luma_offset = offset_reg[OFF_LSB +: 8];
	assign luma_floor_enable_w1 = offset_reg[FLOOR_BIT];
	assign luma_gain_factor_w1 = gain_reg[GAIN_LSB +: 6];
	assign width_reduce_mode_w1 = reduce_e'(gain_reg[REDUCE_LSB +: 2]);
	assign clamp_level_select_w1 = gain_reg[CLAMP_BIT];
	assign offset_adder_skip_w1 = gain_reg[OFF_SKIP_BIT];
	assign gain_multiplier_skip_w1 = gain_reg[GAIN_SKIP_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Sample history and stage 1: skew, lowpass and peaking neighbours.

	logic adv; // Whole pipeline moves; low only in reset and while the buffer is full.
	logic take; // A source sample is accepted.
	logic push; // Stage 5 hands a sample to the buffer.
	pix_in_s tap_reg [TAPS]; // Newest sample in tap 0.
	pix_in_s ctr; // Sample at the filter centre.
	assign s_ready = adv;
	assign take = s_valid && adv;
	assign push = adv && s5_v;
	assign ctr = tap_reg[CENTRE];

	// Newest sample enters the history on every accepted transfer.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tap_reg[0] <= '0;
		end else if (take) begin
			tap_reg[0] <= s_pix;
		end
	end

	// The rest of the history shifts one place per accepted sample.
	genvar gi;
	generate
		for (gi = 1; gi < TAPS; gi++) begin : g_tap
			always_ff @(posedge clk_sys) begin
				if (!nrst) begin
					tap_reg[gi] <= '0;
				end else if (take) begin
					tap_reg[gi] <= tap_reg[gi-1];
				end
			end
		end
	endgenerate

	logic [9:0] skew_y; // Centre luma after half-sample skew filter.
	logic [11:0] lp_sum; // Three-tap lowpass sum.
	logic [10:0] nb_sum; // Sum of the two peaking neighbours.
	logic [9:0] s1_y, s1_nb;
	side_s s1_side;
	always_comb begin
		skew_y = sharp_reg[BYP_SKEW_BIT] ? ctr.y : 10'((11'(ctr.y) + 11'(tap_reg[CENTRE+1].y) + 11'd1) >> 1);
		lp_sum = 12'(tap_reg[CENTRE-1].y) + {1'b0, skew_y, 1'b0} + 12'(tap_reg[CENTRE+1].y);
		case (freq_sel)
			2'b00: nb_sum = 11'(tap_reg[CENTRE-DIST_LOW].y) + 11'(tap_reg[CENTRE+DIST_LOW].y);
			2'b10: nb_sum = 11'(tap_reg[CENTRE-DIST_HIGH].y) + 11'(tap_reg[CENTRE+DIST_HIGH].y);
			default: nb_sum = 11'(tap_reg[CENTRE-DIST_MID].y) + 11'(tap_reg[CENTRE+DIST_MID].y);
		endcase
	end

	// Stage 1 registers filtered luma, neighbour mean, chroma slot and flag.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s1_v <= 1'b0;
			s1_y <= '0;
			s1_nb <= '0;
			s1_side <= '0;
		end else if (adv) begin
			s1_v <= take;
			s1_y <= sharp_reg[BYP_LP_BIT] ? skew_y : lp_sum[11:2];
			s1_nb <= nb_sum[10:1];
			s1_side.act <= sharp_reg[BYP_ACT_BIT] ? ctr.act : tap_reg[CENTRE+1].act;
			s1_side.c <= (ctr.phase ^ sharp_reg[SWAP_BIT]) ? ctr.cr : ctr.cb;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 2: coring and peaking of the high-frequency part.

	// Coring amount in quarter LSBs for a field code.
	function automatic logic [3:0] core_amount(input logic [1:0] code);
		case (code)
			2'b00: core_amount = CORE_Q0;
			2'b01: core_amount = CORE_Q1;
			2'b10: core_amount = CORE_Q2;
			default: core_amount = CORE_Q3;
		endcase
	endfunction

	logic signed [11:0] hf; // Centre minus neighbour mean.
	logic [10:0] hf_mag;
	logic [10:0] cored;
	logic [13:0] boost;
	logic signed [13:0] peak;
	logic signed [13:0] s2_y;
	side_s s2_side;
	always_comb begin
		hf = $signed({2'b00, s1_y}) - $signed({2'b00, s1_nb});
		hf_mag = hf[11] ? 11'(-hf) : hf[10:0];
		cored = (hf_mag > 11'(core_amount(core_sel))) ? hf_mag - 11'(core_amount(core_sel)) : '0;
		boost = (14'(cored) * 14'(peak_gain)) >> 2;
		peak = hf[11] ? -$signed(boost) : $signed(boost);
	end

	// Stage 2 adds the cored, scaled detail back onto the luma.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s2_v <= 1'b0;
			s2_y <= '0;
			s2_side <= '0;
		end else if (adv) begin
			s2_v <= s1_v;
			s2_y <= $signed({4'h0, s1_y}) + peak;
			s2_side <= s1_side;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 3: contrast about the clamp level.

	logic signed [13:0] clamp_q; // Clamp level with two fraction bits.
	logic signed [13:0] dlt;
	logic signed [20:0] prod;
	logic signed [15:0] s3_y;
	side_s s3_side;
	assign clamp_q = $signed({4'h0, clamp_level_select_w1 ? CLAMP_LO : CLAMP_HI, 2'b00});
	assign dlt = s2_y - clamp_q;
	assign prod = dlt * $signed({1'b0, luma_gain_factor_w1});

	// Stage 3 scales distance from the clamp level by the gain factor in 32nds.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s3_v <= 1'b0;
			s3_y <= '0;
			s3_side <= '0;
		end else if (adv) begin
			s3_v <= s2_v;
			s3_side <= s2_side;
			if (gain_multiplier_skip_w1) begin
				s3_y <= 16'(s2_y);
			end else begin
				s3_y <= 16'(clamp_q) + prod[GAIN_FRAC +: 16];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 4: brightness offset.

	logic signed [15:0] off_q; // Offset with two fraction bits.
	logic signed [15:0] s4_y;
	side_s s4_side;
	assign off_q = $signed({{6{luma_offset[7]}}, luma_offset, 2'b00});

	// Stage 4 adds the signed offset unless the adder is skipped.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s4_v <= 1'b0;
			s4_y <= '0;
			s4_side <= '0;
		end else if (adv) begin
			s4_v <= s3_v;
			s4_side <= s3_side;
			s4_y <= offset_adder_skip_w1 ? s3_y : s3_y + off_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 5: reduction to 8 bits, saturation and floor.

	logic [9:0] v_sat; // Luma in 8.2 form, limited to range.
	logic [9:0] sum9;
	logic [10:0] sum10;
	logic [8:0] red;
	logic [1:0] err_next;
	logic [7:0] y8;
	logic [7:0] y_out;
	always_comb begin
		if (s4_y < 0) begin
			v_sat = '0;
		end else if (s4_y > $signed({6'h0, Y10_MAX})) begin
			v_sat = Y10_MAX;
		end else begin
			v_sat = s4_y[9:0];
		end
		sum9 = {1'b0, v_sat[9:1]} + {9'h0, err_reg[0]};
		sum10 = {1'b0, v_sat} + {9'h0, err_reg};
		err_next = err_reg;
		case (width_reduce_mode_w1)
			RED_ROUND: red = 9'(({1'b0, v_sat[9:1]} + 10'h1) >> 1);
			RED_TRUNC: red = {1'b0, v_sat[9:2]};
			RED_ACC1: begin
				red = sum9[9:1];
				err_next = {1'b0, sum9[0]};
			end
			RED_ACC2: begin
				red = sum10[10:2];
				err_next = sum10[1:0];
			end
			default: red = {1'b0, v_sat[9:2]};
		endcase
		y8 = red[8] ? Y8_MAX : red[7:0];
		y_out = (luma_floor_enable_w1 && y8 < FLOOR_LVL) ? FLOOR_LVL : y8;
	end

	pix_out_s s5_pix;
	// The error carry moves only when a real sample passes stage 5.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			err_reg <= '0;
		end else if (adv && s4_v) begin
			err_reg <= err_next;
		end
	end

	// Stage 5 holds the finished sample until the buffer takes it.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s5_v <= 1'b0;
			s5_pix <= '0;
		end else if (adv) begin
			s5_v <= s4_v;
			s5_pix <= '{act: s4_side.act, y: y_out, c: s4_side.c};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output buffer; its free-space flag stalls every stage.

	sample_fifo #(
		.WIDTH($bits(pix_out_s)),
		.DEPTH(FIFO_DEPTH)
	) u_out_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(s5_v),
		.in_ready(adv),
		.in_data(s5_pix),
		.out_valid(m_valid),
		.out_ready(m_ready),
		.out_data(m_pix),
		.level(fifo_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the pipeline.

	property p_core_small;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && hf_mag <= 11'(core_amount(core_sel))) |=> (s2_y == $signed({4'h0, $past(s1_y)}));
	endproperty
	a_core_small: assert property (p_core_small) else $error("Small detail not cored away.");

	property p_no_peak;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && peak_gain == 3'h0) |=> (s2_y == $signed({4'h0, $past(s1_y)}));
	endproperty
	a_no_peak: assert property (p_no_peak) else $error("Peaking active at gain zero.");

	property p_swap;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && (ctr.phase ^ sharp_reg[SWAP_BIT])) |=> (s1_side.c == $past(ctr.cr));
	endproperty
	a_swap: assert property (p_swap) else $error("Chroma slot order wrong.");

	property p_offset;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && !offset_adder_skip_w1) |=> (s4_y == $past(s3_y) + $past(off_q));
	endproperty
	a_offset: assert property (p_offset) else $error("Offset not added.");

	property p_floor;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && s4_v && luma_floor_enable_w1) |=> (s5_pix.y >= FLOOR_LVL);
	endproperty
	a_floor: assert property (p_floor) else $error("Luma below floor.");

	property p_unity;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && !gain_multiplier_skip_w1 && luma_gain_factor_w1 == GAIN_UNITY) |=> (s3_y == 16'($past(s2_y)));
	endproperty
	a_unity: assert property (p_unity) else $error("Unity gain altered luma.");

	property p_trunc;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && width_reduce_mode_w1 == RED_TRUNC && !luma_floor_enable_w1) |=> (s5_pix.y == $past(v_sat[9:2]));
	endproperty
	a_trunc: assert property (p_trunc) else $error("Truncation result wrong.");

	property p_clamp;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && !gain_multiplier_skip_w1 && luma_gain_factor_w1 == 6'h0) |=> (s3_y == 16'($past(clamp_q)));
	endproperty
	a_clamp: assert property (p_clamp) else $error("Zero gain missed clamp level.");

	property p_skips;
		@(posedge clk_sys) disable iff (!nrst)
		(adv && offset_adder_skip_w1 && gain_multiplier_skip_w1) ##1 (adv && offset_adder_skip_w1)
			|=> (s4_y == 16'($past(s2_y, 2)));
	endproperty
	a_skips: assert property (p_skips) else $error("Skipped stages changed luma.");

	property p_stall;
		@(posedge clk_sys) disable iff (!nrst)
		(!adv && s5_v) |=> (s5_v && $stable(s5_pix));
	endproperty
	a_stall: assert property (p_stall) else $error("Stalled sample lost.");

	c_take: cover property (@(posedge clk_sys) disable iff (!nrst) take ##5 push);
	c_full: cover property (@(posedge clk_sys) disable iff (!nrst) s5_v && !adv);
	c_acc2: cover property (@(posedge clk_sys) disable iff (!nrst) push && width_reduce_mode_w1 == RED_ACC2);
endmodule
`default_nettype wire

// *** design/luma_adjust_pkg.sv ***
// Constants, field layouts and carrier types for the luma sharpness and level stage.
// Assumes one pixel clock and an APB master that owns the register bus.
package luma_adjust_pkg;
	// Printed register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_SHARP = 12'h126;
	localparam logic [11:0] IDX_OFFSET = 12'h127;
	localparam logic [11:0] IDX_GAIN = 12'h128;
	localparam logic [11:0] IDX_STATUS = 12'h129;
	localparam logic [11:0] ADDR_SHARP = {IDX_SHARP[9:0], 2'b00};
	localparam logic [11:0] ADDR_OFFSET = {IDX_OFFSET[9:0], 2'b00};
	localparam logic [11:0] ADDR_GAIN = {IDX_GAIN[9:0], 2'b00};
	localparam logic [11:0] ADDR_STATUS = {IDX_STATUS[9:0], 2'b00};
	// Reset values; the peaking centre field starts at the middle setting.
	localparam logic [11:0] SHARP_RST = 12'h200;
	localparam logic [11:0] OFFSET_RST = 12'h000;
	localparam logic [11:0] GAIN_RST = 12'h020;
	// Writable bit masks; reserved bits are stored as zero.
	localparam logic [11:0] SHARP_MASK = 12'h7ff;
	localparam logic [11:0] OFFSET_MASK = 12'h8ff;
	localparam logic [11:0] GAIN_MASK = 12'h7ff;
	// Field positions in the sharpness and coring word.
	localparam int CORE_LSB = 0;
	localparam int PEAK_LSB = 2;
	localparam int BYP_LP_BIT = 5;
	localparam int BYP_SKEW_BIT = 6;
	localparam int BYP_ACT_BIT = 7;
	localparam int SWAP_BIT = 8;
	localparam int FREQ_LSB = 9;
	// Field positions in the offset word.
	localparam int OFF_LSB = 0;
	localparam int FLOOR_BIT = 11;
	// Field positions in the gain word.
	localparam int GAIN_LSB = 0;
	localparam int REDUCE_LSB = 6;
	localparam int CLAMP_BIT = 8;
	localparam int OFF_SKIP_BIT = 9;
	localparam int GAIN_SKIP_BIT = 10;
	// Coring amounts in quarter LSBs, the resolution of the luma path.
	localparam logic [3:0] CORE_Q0 = 4'h0;
	localparam logic [3:0] CORE_Q1 = 4'h2;
	localparam logic [3:0] CORE_Q2 = 4'h4;
	localparam logic [3:0] CORE_Q3 = 4'h8;
	// Peaking neighbour distances for low, middle and high centre.
	localparam int DIST_LOW = 4;
	localparam int DIST_MID = 2;
	localparam int DIST_HIGH = 1;
	localparam int TAPS = 9;
	localparam int CENTRE = 4;
	// Luma levels in whole 8-bit codes; Y10_MAX is in 8.2 form.
	localparam logic [7:0] CLAMP_HI = 8'h20;
	localparam logic [7:0] CLAMP_LO = 8'h10;
	localparam logic [7:0] FLOOR_LVL = 8'h10;
	localparam logic [7:0] Y8_MAX = 8'hff;
	localparam logic [9:0] Y10_MAX = 10'h3ff;
	localparam logic [5:0] GAIN_UNITY = 6'h20;
	localparam int GAIN_FRAC = 5;
	localparam int FIFO_DEPTH = 8;
	// Width reduction methods, in field code order.
	typedef enum logic [1:0] {RED_ROUND, RED_TRUNC, RED_ACC1, RED_ACC2} reduce_e;
	// Input sample: luma with two fraction bits, chroma pair, pair phase.
	typedef struct packed {
		logic act;
		logic phase;
		logic [9:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} pix_in_s;
	// Output sample: 8-bit luma and the chroma chosen for this slot.
	typedef struct packed {
		logic act;
		logic [7:0] y;
		logic [7:0] c;
	} pix_out_s;
	// Side data that travels beside luma through the stages.
	typedef struct packed {
		logic act;
		logic [7:0] c;
	} side_s;
endpackage

// *** design/sample_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
// Assumes push and pop come from the same clock as the storage.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output var logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output var logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output var logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage words.
	logic [AW-1:0] wr_reg; // Write index.
	logic [AW-1:0] rd_reg; // Read index.
	logic [AW:0] level_next; // Fill after this edge.
	logic push;
	logic pop;

	// Handshakes on both sides.
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign level_next = level + (AW + 1)'(push) - (AW + 1)'(pop);
	assign out_data = mem_reg[rd_reg];

	// Storage is written only at a taken push.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	// Indices, fill level and the flags derived from it.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			level <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
			end
			level <= level_next;
			in_ready <= (level_next != FULL);
			out_valid <= (level_next != '0);
		end
	end
endmodule
`default_nettype wire

// *** testbench/video_sink_model.sv ***
// Downstream capture model that consumes output samples.
// Assumes the bench picks the stall mode at clock edges.
`timescale 1ns/1ps
`default_nettype none
module video_sink_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [1:0] mode,
	output logic m_ready
);
	logic [31:0] lf; // Stall pattern source.
	////////////////////////////////////////////////////////////
	// Mode 0 always takes, mode 1 stalls at random, mode 2 never takes.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			lf <= 32'h1234abcd;
		end else begin
			lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		end
		m_ready <= (mode == 2'h0) | ((mode == 2'h1) & lf[3]);
	end
endmodule
`default_nettype wire

// *** testbench/luma_sharpness_level_adjust_bench.sv ***
// Bench: register access over APB and flat luma streams through the stage.
// Assumes the package and both design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module luma_sharpness_level_adjust_bench;
	import luma_adjust_pkg::*;
	logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, s_valid = 0, ph_q = 0, er;
	logic [11:0] paddr = 0, off, g;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'h3eb0246d;
	logic pready, pslverr, s_ready, m_valid, m_ready;
	logic [9:0] cur_y = 0, y;
	logic [7:0] cur_cb = 0, cur_cr = 0;
	logic [1:0] sink_mode = 0;
	pix_in_s s_pix;
	pix_out_s m_pix;
	pix_out_s outq [0:511]; // Delivered samples in order.
	logic ph [0:511]; // Chroma phase of each accepted sample.
	int takes = 0, outs = 0, cyc = 0, errors = 0, checks_done = 0;
	////////////////////////////////////////////////////////////
	always #4 clk_sys = ~clk_sys;
	assign s_pix = '{act: 1'b1, phase: ph_q, y: cur_y, cb: cur_cb, cr: cur_cr};
	luma_sharpness_level_adjust u_dut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready), .s_pix(s_pix), .m_valid(m_valid),
		.m_ready(m_ready), .m_pix(m_pix));
	video_sink_model u_sink (.clk_sys(clk_sys), .nrst(nrst), .mode(sink_mode), .m_ready(m_ready));
	// Logs takes and deliveries, and cuts a hang short.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (s_valid && s_ready) begin
			ph[takes] <= ph_q;
			takes <= takes + 1;
			ph_q <= ~ph_q;
		end
		if (m_valid && m_ready) begin
			outq[outs] <= m_pix;
			outs <= outs + 1;
		end
		if (cyc == 20000) begin
			errors = errors + 1;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Gain about the clamp pivot, offset, reduction, saturation, floor.
	function automatic logic [7:0] exp_y(input logic [9:0] y, input logic [11:0] o, input logic [11:0] g);
		int v, c4;
		c4 = g[8] ? 64 : 128;
		v = y;
		if (!g[10]) v = c4 + ((v - c4) * int'(g[5:0])) / 32;
		if (!g[9]) v = v + 4 * int'($signed(o[7:0]));
		if (g[7:6] == 2'h0) v = ((v >>> 1) + 1) >>> 1;
		else v = v >>> 2;
		if (v < 0) v = 0;
		if (v > 255) v = 255;
		if (o[11] && v < 16) v = 16;
		return v[7:0];
	endfunction
	task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] v);
		checks_done++;
		if (v !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, v);
		end
	endtask
	task automatic cmp_pix(input string n, input pix_out_s e, input pix_out_s v);
		checks_done++;
		if (v !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, v);
		end
	endtask
	// One APB transfer; holds the request until pready is seen.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic send(input int n);
		int c;
		c = 0;
		s_valid <= 1'b1;
		while (c < n) begin
			@(posedge clk_sys);
			if (s_ready === 1'b1) c++;
		end
		s_valid <= 1'b0;
	endtask
	// Sixteen equal samples; the last six have a full same-setting history.
	task automatic group(input logic [11:0] o, input logic [11:0] gw, input logic [9:0] yv);
		int b;
		pix_out_s e;
		seed = lfsr(seed);
		apb(ADDR_SHARP, 1'b1, {20'h0, seed[11:0] & SHARP_MASK}, rd, er);
		apb(ADDR_OFFSET, 1'b1, {20'h0, o}, rd, er);
		apb(ADDR_GAIN, 1'b1, {20'h0, gw}, rd, er);
		b = takes;
		cur_y <= yv;
		cur_cb <= seed[23:16];
		cur_cr <= seed[31:24];
		sink_mode <= {1'b0, seed[12]};
		send(16);
		while (outs != takes) @(posedge clk_sys);
		for (int j = b + 10; j < b + 16; j++) begin
			e = '{act: 1'b1, y: exp_y(yv, o, gw), c: (ph[j-5] ^ seed[8]) ? seed[31:24] : seed[23:16]};
			cmp_pix("luma out", e, outq[j]);
		end
		$display("group from sample %0d done", b);
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence: registers, corner groups, random groups, full buffer.
	initial begin
		logic [11:0] ad [3];
		logic [11:0] rs [3];
		logic [11:0] mk [3];
		ad = '{ADDR_SHARP, ADDR_OFFSET, ADDR_GAIN};
		rs = '{SHARP_RST, OFFSET_RST, GAIN_RST};
		mk = '{SHARP_MASK, OFFSET_MASK, GAIN_MASK};
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 3; i++) begin
			apb(ad[i], 1'b0, 32'h0, rd, er);
			cmp_word("reset value", {20'h0, rs[i]}, rd);
			apb(ad[i], 1'b1, 32'hffffffff, rd, er);
			apb(ad[i], 1'b0, 32'h0, rd, er);
			cmp_word("reserved bits", {20'h0, mk[i]}, rd);
		end
		apb(12'h000, 1'b0, 32'h0, rd, er);
		cmp_word("unmapped error", 32'h1, {31'h0, er});
		$display("register test done");
		group(12'h880, 12'h020, 10'h0c0);
		group(12'h07f, 12'h13f, 10'h3e0);
		group(12'h000, 12'h400, 10'h0fe);
		group(12'h0ff, 12'h640, 10'h0ff);
		group(12'h000, 12'h100, 10'h200);
		group(12'h000, 12'h000, 10'h200);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			off = seed[11:0] & OFFSET_MASK;
			g = seed[23:12] & GAIN_MASK;
			// Carry modes: a gain in steps of four keeps the result on whole codes, so no dither.
			if (g[7]) g[1:0] = 2'h0;
			seed = lfsr(seed);
			if (g[10]) y = {seed[9:2], g[7] ? 2'h0 : seed[1:0]};
			else y = (g[8] ? 10'h040 : 10'h080) + {seed[4:0] % 5'h1a, 5'h0} - 10'h040;
			group(off, g, y);
		end
		sink_mode <= 2'h2;
		fork
			send(20);
			begin
				repeat (40) @(posedge clk_sys);
				cmp_word("ready when full", 32'h0, {31'h0, s_ready});
				apb(ADDR_STATUS, 1'b0, 32'h0, rd, er);
				cmp_word("fifo level", 32'(FIFO_DEPTH), rd & 32'hf);
				sink_mode <= 2'h1;
			end
		join
		while (outs != takes) @(posedge clk_sys);
		apb(ADDR_STATUS, 1'b0, 32'h0, rd, er);
		cmp_word("idle status", 32'h0, rd & 32'h3f);
		$display("buffer test done");
		end_sim();
	end
endmodule
`default_nettype wire
